//--- core/rsmc_pkg.sv
`default_nettype none

package rsmc_pkg;

  // ==========================================================================
  // Strap positions in the strap vector.
  localparam int unsigned STRAP_COUNT = 7;
  localparam int unsigned STRAP_BOOT = 0;
  localparam int unsigned STRAP_IRQ = 1;
  localparam int unsigned STRAP_LINK = 2;
  localparam int unsigned STRAP_CFGWE = 3;
  localparam int unsigned STRAP_TMA = 4;
  localparam int unsigned STRAP_TMB = 5;
  localparam int unsigned STRAP_TMC = 6;

  // ==========================================================================
  // Default levels set by the internal pulls while reset is low.
  localparam logic [STRAP_COUNT-1:0] STRAP_DEFAULTS = 7'h70;
  // Straps whose reset pull is only fitted on processor zero.
  localparam logic [STRAP_COUNT-1:0] STRAP_PULL_ID0_ONLY = 7'h09;
  // Straps pulled up in reset; the rest are pulled down.
  localparam logic [STRAP_COUNT-1:0] STRAP_RESET_PULLUP = 7'h70;
  // Straps that keep a pull-up on processor zero in normal operation.
  localparam logic [STRAP_COUNT-1:0] STRAP_RUN_PULLUP_ID0 = 7'h09;

  // ==========================================================================
  // Timing.
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned HANDOVER_TIME_NS = 20;
  localparam int unsigned HANDOVER_CYCLES_RAW = (HANDOVER_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned HANDOVER_CYCLES = (HANDOVER_CYCLES_RAW < 1) ? 1 : HANDOVER_CYCLES_RAW;
  localparam int unsigned HANDOVER_CNT_W = 4;

  // ==========================================================================
  // Reset values.
  localparam logic [HANDOVER_CNT_W-1:0] HANDOVER_CNT_RESET = 4'h0;
  localparam logic [STRAP_COUNT-1:0] STRAP_VEC_RESET = 7'h00;

  // ==========================================================================
  // Types.
  typedef enum logic [1:0] {
    RSMC_HOLD = 2'h0,
    RSMC_CAPTURE = 2'h1,
    RSMC_HANDOVER = 2'h3,
    RSMC_RUN = 2'h2
  } rsmc_state_type;

  typedef struct packed {
    logic test_mode_strap_c;
    logic test_mode_strap_b;
    logic test_mode_strap_a;
    logic config_reg_write_strap;
    logic link_rx_width_strap;
    logic ext_interrupt_enable_strap;
    logic boot_source_strap;
  } rsmc_straps_type;

  typedef struct packed {
    logic [STRAP_COUNT-1:0] pull_up_en;
    logic [STRAP_COUNT-1:0] pull_down_en;
    logic [STRAP_COUNT-1:0] func_en;
  } rsmc_pad_type;

  localparam rsmc_pad_type PAD_RESET = '{pull_up_en: 7'h00, pull_down_en: 7'h00, func_en: 7'h00};

endpackage : rsmc_pkg

`default_nettype wire

//--- core/rsmc_sync.sv
`timescale 1ns/1ps
`default_nettype none

module rsmc_sync
  import rsmc_pkg::*;
#(
  parameter int unsigned WIDTH = 1
) (
  // Clock and reset.
  input wire logic clk_sys_in,
  input wire logic srst_in,
  // Asynchronous levels in, synchronised levels out.
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  // ==========================================================================
  // Two flip-flops per bit; the first stage feeds only the second.
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] sync_d;

  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    always_comb begin
      meta_d[i] = async_in[i];
      sync_d[i] = meta_q[i];
    end

    always_ff @(posedge clk_sys_in) begin
      if (srst_in) begin
        meta_q[i] <= 1'b0;
        sync_q[i] <= 1'b0;
      end else begin
        meta_q[i] <= meta_d[i];
        sync_q[i] <= sync_d[i];
      end
    end
  end

  assign sync_out = sync_q;

endmodule : rsmc_sync

`default_nettype wire

//--- core/rsmc_pad_ctrl.sv
`timescale 1ns/1ps
`default_nettype none

module rsmc_pad_ctrl
  import rsmc_pkg::*;
(
  // Phase of the capture sequence.
  input wire logic in_reset_in,
  input wire logic functional_in,
  input wire logic proc_id_zero_in,
  // Pad resistor and function selects.
  output rsmc_pad_type pad_out
);

  // ==========================================================================
  // Per-pin resistor choice; reset pulls set the strap defaults.
  for (genvar i = 0; i < STRAP_COUNT; i++) begin : g_pad
    logic pull_fitted;

    always_comb begin
      pull_fitted = proc_id_zero_in | ~STRAP_PULL_ID0_ONLY[i];
      pad_out.pull_up_en[i] = 1'b0;
      pad_out.pull_down_en[i] = 1'b0;
      pad_out.func_en[i] = 1'b0;
      if (in_reset_in) begin
        pad_out.pull_up_en[i] = pull_fitted & STRAP_RESET_PULLUP[i];
        pad_out.pull_down_en[i] = pull_fitted & ~STRAP_RESET_PULLUP[i];
      end else begin
        // Pins that keep a pull after release are still driven by this pad once functional_in is set.
        pad_out.pull_up_en[i] = proc_id_zero_in & STRAP_RUN_PULLUP_ID0[i];
        pad_out.func_en[i] = functional_in;
      end
    end
  end

endmodule : rsmc_pad_ctrl

`default_nettype wire

//--- core/rsmc_capture.sv
`timescale 1ns/1ps
`default_nettype none

module rsmc_capture
  import rsmc_pkg::*;
(
  // Clock and reset.
  input wire logic clk_sys_in,
  input wire logic srst_in,
  // Device reset pin and strap pins.
  input wire logic rst_pin_n_in,
  input wire logic [STRAP_COUNT-1:0] strap_pins_in,
  input wire logic proc_id_zero_in,
  // Configuration register write requests.
  input wire logic cfg_write_req_in,
  // Pad control.
  output logic [STRAP_COUNT-1:0] pad_pull_up_en_out,
  output logic [STRAP_COUNT-1:0] pad_pull_down_en_out,
  output logic [STRAP_COUNT-1:0] pad_func_en_out,
  // Latched mode settings.
  output rsmc_straps_type straps_out,
  output logic straps_valid_out,
  output logic boot_from_memory_out,
  output logic boot_wait_external_out,
  output logic ext_irq_enable_out,
  output logic ext_irq_level_sense_out,
  output logic link_rx_width_4bit_out,
  output logic cfg_write_grant_out
);

  // ==========================================================================
  // Input synchronisers.
  logic [STRAP_COUNT:0] raw_vec;
  logic [STRAP_COUNT:0] sync_vec;
  logic rst_pin_s;
  logic [STRAP_COUNT-1:0] strap_s;
  logic id_zero_s;

  assign raw_vec = {rst_pin_n_in, strap_pins_in};

  rsmc_sync #(
    .WIDTH(STRAP_COUNT + 1)
  ) u_sync_pins (
    .clk_sys_in(clk_sys_in),
    .srst_in(srst_in),
    .async_in(raw_vec),
    .sync_out(sync_vec)
  );

  rsmc_sync #(
    .WIDTH(1)
  ) u_sync_id (
    .clk_sys_in(clk_sys_in),
    .srst_in(srst_in),
    .async_in(proc_id_zero_in),
    .sync_out(id_zero_s)
  );

  assign rst_pin_s = sync_vec[STRAP_COUNT];
  assign strap_s = sync_vec[STRAP_COUNT-1:0];

  // ==========================================================================
  // Release edge detection.
  // The reset pin and the straps share one synchroniser, so the strap sample
  // taken one cycle before the edge is the level present while reset was low.
  // A block reset with the pin already high is read as a fresh release, and the
  // straps then come from the cleared synchronisers, so srst_in is only meant to
  // be raised while the reset pin is held low.
  logic rst_prev_q;
  logic rst_prev_d;
  logic [STRAP_COUNT-1:0] strap_prev_q;
  logic [STRAP_COUNT-1:0] strap_prev_d;
  logic release_edge;

  always_comb begin
    rst_prev_d = rst_pin_s;
    strap_prev_d = strap_s;
  end

  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      rst_prev_q <= 1'b0;
      strap_prev_q <= STRAP_VEC_RESET;
    end else begin
      rst_prev_q <= rst_prev_d;
      strap_prev_q <= strap_prev_d;
    end
  end

  assign release_edge = rst_pin_s & ~rst_prev_q;

  // ==========================================================================
  // Sequence state machine.
  rsmc_state_type state_q;
  rsmc_state_type state_d;
  logic [HANDOVER_CNT_W-1:0] hand_cnt_q;
  logic [HANDOVER_CNT_W-1:0] hand_cnt_d;

  always_comb begin
    state_d = state_q;
    hand_cnt_d = hand_cnt_q;
    if (!rst_pin_s) begin
      state_d = RSMC_HOLD;
      hand_cnt_d = HANDOVER_CNT_RESET;
    end else begin
      case (state_q)
        RSMC_HOLD: begin
          if (release_edge) begin
            state_d = RSMC_CAPTURE;
          end
        end
        RSMC_CAPTURE: begin
          state_d = RSMC_HANDOVER;
          hand_cnt_d = HANDOVER_CNT_RESET;
        end
        RSMC_HANDOVER: begin
          // Pins stay as inputs a short while so the capture settles first.
          if (hand_cnt_q == HANDOVER_CNT_W'(HANDOVER_CYCLES - 1)) begin
            state_d = RSMC_RUN;
          end else begin
            hand_cnt_d = hand_cnt_q + 4'h1;
          end
        end
        RSMC_RUN: begin
          state_d = RSMC_RUN;
        end
        default: begin
          state_d = RSMC_HOLD;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      state_q <= RSMC_HOLD;
      hand_cnt_q <= HANDOVER_CNT_RESET;
    end else begin
      state_q <= state_d;
      hand_cnt_q <= hand_cnt_d;
    end
  end

  // ==========================================================================
  // Strap latch.
  // The latch is loaded only at the release edge and is not cleared when the
  // pin goes low again, so the old modes hold until the next capture.
  rsmc_straps_type straps_q;
  rsmc_straps_type straps_d;
  logic valid_q;
  logic valid_d;

  always_comb begin
    straps_d = straps_q;
    valid_d = valid_q;
    if (release_edge && state_q == RSMC_HOLD) begin
      straps_d = rsmc_straps_type'(strap_prev_q);
      valid_d = 1'b1;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      straps_q <= rsmc_straps_type'(STRAP_DEFAULTS);
      valid_q <= 1'b0;
    end else begin
      straps_q <= straps_d;
      valid_q <= valid_d;
    end
  end

  // ==========================================================================
  // Decoded modes.
  // Decoded controls follow the latch one cycle later and are not used by
  // the rest of the chip until the pins have been handed back.
  logic boot_mem_q;
  logic boot_mem_d;
  logic boot_wait_q;
  logic boot_wait_d;
  logic irq_en_q;
  logic irq_en_d;
  logic irq_level_q;
  logic irq_level_d;
  logic link4_q;
  logic link4_d;

  always_comb begin
    boot_mem_d = ~straps_q.boot_source_strap;
    boot_wait_d = straps_q.boot_source_strap;
    irq_en_d = straps_q.ext_interrupt_enable_strap;
    irq_level_d = straps_q.ext_interrupt_enable_strap;
    link4_d = straps_q.link_rx_width_strap;
  end

  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      boot_mem_q <= ~STRAP_DEFAULTS[STRAP_BOOT];
      boot_wait_q <= STRAP_DEFAULTS[STRAP_BOOT];
      irq_en_q <= STRAP_DEFAULTS[STRAP_IRQ];
      irq_level_q <= STRAP_DEFAULTS[STRAP_IRQ];
      link4_q <= STRAP_DEFAULTS[STRAP_LINK];
    end else begin
      boot_mem_q <= boot_mem_d;
      boot_wait_q <= boot_wait_d;
      irq_en_q <= irq_en_d;
      irq_level_q <= irq_level_d;
      link4_q <= link4_d;
    end
  end

  // ==========================================================================
  // Configuration register write permission.
  // In one-time mode the first granted write closes the window until the
  // next capture; writes before the pins are handed back are not granted.
  logic cfg_used_q;
  logic cfg_used_d;
  logic grant_q;
  logic grant_d;
  logic write_open;

  assign write_open = (state_q == RSMC_RUN) && (straps_q.config_reg_write_strap || !cfg_used_q);

  always_comb begin
    cfg_used_d = cfg_used_q;
    grant_d = 1'b0;
    if (release_edge) begin
      cfg_used_d = 1'b0;
    end else if (cfg_write_req_in && write_open) begin
      grant_d = 1'b1;
      cfg_used_d = 1'b1;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      cfg_used_q <= 1'b0;
      grant_q <= 1'b0;
    end else begin
      cfg_used_q <= cfg_used_d;
      grant_q <= grant_d;
    end
  end

  // ==========================================================================
  // Pad resistors and pin function.
  // Test-mode pads keep their pull-ups in reset; nothing here can detect an
  // overdrive, so the board must leave them alone.
  // Between capture and hand-back the pads do not drive and pull only the boot and write straps up,
  // on processor zero; the straps are already latched by then, so a floating level does no harm.
  rsmc_pad_type pad_comb;
  rsmc_pad_type pad_q;
  rsmc_pad_type pad_d;

  rsmc_pad_ctrl u_pad_ctrl (
    .in_reset_in(state_q == RSMC_HOLD),
    .functional_in(state_q == RSMC_RUN),
    .proc_id_zero_in(id_zero_s),
    .pad_out(pad_comb)
  );

  always_comb begin
    pad_d = pad_comb;
  end

  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      pad_q <= PAD_RESET;
    end else begin
      pad_q <= pad_d;
    end
  end

  // ==========================================================================
  // Outputs.
  assign pad_pull_up_en_out = pad_q.pull_up_en;
  assign pad_pull_down_en_out = pad_q.pull_down_en;
  assign pad_func_en_out = pad_q.func_en;
  assign straps_out = straps_q;
  assign straps_valid_out = valid_q;
  assign boot_from_memory_out = boot_mem_q;
  assign boot_wait_external_out = boot_wait_q;
  assign ext_irq_enable_out = irq_en_q;
  assign ext_irq_level_sense_out = irq_level_q;
  assign link_rx_width_4bit_out = link4_q;
  assign cfg_write_grant_out = grant_q;

endmodule : rsmc_capture

`default_nettype wire

//--- core/rsmc_end.sv
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

//--- sim/rsmc_capture_sva.sv
`timescale 1ns/1ps
`default_nettype none

module rsmc_capture_sva
  import rsmc_pkg::*;
(
  // Clock, reset and inputs.
  input wire logic clk_sys_in,
  input wire logic srst_in,
  input wire logic rst_pin_n_in,
  input wire logic [STRAP_COUNT-1:0] strap_pins_in,
  input wire logic proc_id_zero_in,
  input wire logic cfg_write_req_in,
  // Outputs of the capture block.
  input wire logic [STRAP_COUNT-1:0] pad_pull_up_en_out,
  input wire logic [STRAP_COUNT-1:0] pad_pull_down_en_out,
  input wire logic [STRAP_COUNT-1:0] pad_func_en_out,
  input wire rsmc_straps_type straps_out,
  input wire logic straps_valid_out,
  input wire logic boot_from_memory_out,
  input wire logic boot_wait_external_out,
  input wire logic ext_irq_enable_out,
  input wire logic ext_irq_level_sense_out,
  input wire logic link_rx_width_4bit_out,
  input wire logic cfg_write_grant_out
);
  // ==========================================================================
  // Checks. The decoded modes trail the straps by one cycle, hence $stable.
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (srst_in);

  AST_BOOT_DECODE: assert property ($stable(straps_out) |->
    boot_from_memory_out == !straps_out.boot_source_strap && boot_wait_external_out == straps_out.boot_source_strap)
    else $error("boot mode decode wrong");
  AST_IRQ_DECODE: assert property ($stable(straps_out) |->
    ext_irq_enable_out == straps_out.ext_interrupt_enable_strap &&
    ext_irq_level_sense_out == straps_out.ext_interrupt_enable_strap)
    else $error("interrupt mode decode wrong");
  AST_LINK_DECODE: assert property ($stable(straps_out) |->
    link_rx_width_4bit_out == straps_out.link_rx_width_strap)
    else $error("link width decode wrong");
  AST_HOLD_IN_RUN: assert property (pad_func_en_out == 7'h7F && $past(pad_func_en_out) == 7'h7F |->
    $stable(straps_out)) else $error("straps changed in normal operation");
  AST_HOLD_IN_RESET: assert property (!rst_pin_n_in [*3] |=> $stable(straps_out))
    else $error("straps changed while reset pin low");
  AST_HANDOVER: assert property ($rose(rst_pin_n_in) ##1 rst_pin_n_in [*8] |=>
    pad_func_en_out == 7'h7F && straps_valid_out) else $error("pins not handed back after release");
  AST_RESET_PULLS: assert property ((!rst_pin_n_in && proc_id_zero_in) [*6] |->
    pad_pull_up_en_out == 7'h70 && pad_pull_down_en_out == 7'h0F && pad_func_en_out == 7'h00)
    else $error("reset pulls wrong");
  AST_RESET_PULLS_NOT_ID0: assert property ((!rst_pin_n_in && !proc_id_zero_in) [*6] |->
    pad_pull_up_en_out == 7'h70 && pad_pull_down_en_out == 7'h06 && pad_func_en_out == 7'h00)
    else $error("reset pulls off processor zero wrong");
  AST_RUN_PULLUP: assert property ((rst_pin_n_in && proc_id_zero_in) [*4] ##0 pad_func_en_out == 7'h7F |->
    pad_pull_up_en_out == 7'h09 && pad_pull_down_en_out == 7'h00) else $error("run pulls wrong");
  AST_GRANT_ONCE: assert property (cfg_write_grant_out && !straps_out.config_reg_write_strap |=>
    !cfg_write_grant_out [*8]) else $error("second grant in one-time mode");
  AST_GRANT_ALWAYS: assert property (rst_pin_n_in [*4] ##0 (straps_out.config_reg_write_strap &&
    cfg_write_req_in && pad_func_en_out == 7'h7F) |=> cfg_write_grant_out) else $error("write not granted");
endmodule : rsmc_capture_sva

`default_nettype wire

//--- sim/rsmc_strap_board.sv
`timescale 1ns/1ps
`default_nettype none

module rsmc_strap_board
  import rsmc_pkg::*;
(
  // Clock for the floating pattern.
  input wire logic clk_sys_in,
  // Pad state from the device and board overrides.
  input wire logic [STRAP_COUNT-1:0] pull_up_en_in,
  input wire logic [STRAP_COUNT-1:0] pull_down_en_in,
  input wire logic [STRAP_COUNT-1:0] func_en_in,
  input wire logic [STRAP_COUNT-1:0] ovr_en_in,
  input wire logic [STRAP_COUNT-1:0] ovr_val_in,
  // Pin levels.
  output logic [STRAP_COUNT-1:0] pins_out
);
  // ==========================================================================
  // An undriven pin toggles, so a missing pull never reads as a lucky level.
  logic [STRAP_COUNT-1:0] float_q = 7'h55;
  logic [STRAP_COUNT-1:0] ovr_ok;

  always @(posedge clk_sys_in) float_q <= ~float_q;
  assign ovr_ok = ovr_en_in & 7'h0F;

  always_comb begin
    for (int i = 0; i < STRAP_COUNT; i++) begin
      if (ovr_ok[i]) pins_out[i] = ovr_val_in[i];
      else if (func_en_in[i]) pins_out[i] = float_q[i];
      else if (pull_up_en_in[i]) pins_out[i] = 1'b1;
      else if (pull_down_en_in[i]) pins_out[i] = 1'b0;
      else pins_out[i] = ~float_q[i];
    end
  end
endmodule : rsmc_strap_board

`default_nettype wire

//--- sim/tb_reset_strap_mode_capture.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin mismatches++; \
  $display("unexpected %s expected %h seen %h", nm, e, g); end end

module tb_reset_strap_mode_capture
  import rsmc_pkg::*;
;
  // ==========================================================================
  // Signals.
  logic clk_sys_in, srst_in, rst_pin_n_in, proc_id_zero_in, cfg_write_req_in;
  logic [STRAP_COUNT-1:0] pins, pu, pd, fe, ovr_en, ovr_val, last, fe_prev;
  logic valid, boot_mem, boot_wait, irq_en, irq_lvl, link4, grant;
  rsmc_straps_type straps;
  logic [STRAP_COUNT-1:0] exp_q[$];
  int mismatches, total_checks, grants, i;

  rsmc_capture DUT (.clk_sys_in(clk_sys_in), .srst_in(srst_in), .rst_pin_n_in(rst_pin_n_in),
    .strap_pins_in(pins), .proc_id_zero_in(proc_id_zero_in), .cfg_write_req_in(cfg_write_req_in),
    .pad_pull_up_en_out(pu), .pad_pull_down_en_out(pd), .pad_func_en_out(fe), .straps_out(straps),
    .straps_valid_out(valid), .boot_from_memory_out(boot_mem), .boot_wait_external_out(boot_wait),
    .ext_irq_enable_out(irq_en), .ext_irq_level_sense_out(irq_lvl), .link_rx_width_4bit_out(link4),
    .cfg_write_grant_out(grant));
  rsmc_strap_board board (.clk_sys_in(clk_sys_in), .pull_up_en_in(pu), .pull_down_en_in(pd),
    .func_en_in(fe), .ovr_en_in(ovr_en), .ovr_val_in(ovr_val), .pins_out(pins));

  // ==========================================================================
  // Monitor: each hand-back of the pins closes one capture.
  always @(negedge clk_sys_in) begin
    if (grant === 1'b1) grants++;
    if (fe === 7'h7F && fe_prev !== 7'h7F) begin
      `CHK("capture pending", 1'b1, exp_q.size() != 0)
      if (exp_q.size() != 0) begin
        last = exp_q.pop_front();
        `CHK("straps", last, straps)
        `CHK("valid", 1'b1, valid)
        `CHK("boot from memory", !last[0], boot_mem)
        `CHK("boot wait", last[0], boot_wait)
        `CHK("irq enable", last[1], irq_en)
        `CHK("irq level", last[1], irq_lvl)
        `CHK("link width", last[2], link4)
        `CHK("run pull-up", proc_id_zero_in ? 7'h09 : 7'h00, pu)
      end
    end
    fe_prev = fe;
  end

  // ==========================================================================
  // Drivers.
  task automatic capture(input logic [3:0] en, input logic [3:0] val);
    int n;
    int g0;
    @(negedge clk_sys_in) rst_pin_n_in = 1'b0;
    repeat (8) @(negedge clk_sys_in);
    if (valid === 1'b1) `CHK("held straps", last, straps)
    ovr_en = {3'h0, en};
    ovr_val = {3'h0, val};
    repeat (4) @(negedge clk_sys_in);
    exp_q.push_back({3'h7, en & val});
    g0 = grants;
    rst_pin_n_in = 1'b1;
    @(negedge clk_sys_in) cfg_write_req_in = 1'b1;
    @(negedge clk_sys_in) cfg_write_req_in = 1'b0;
    repeat (3) @(negedge clk_sys_in);
    ovr_en = 7'h0F;
    ovr_val = 7'($urandom);
    n = 0;
    while (exp_q.size() != 0 && n < 40) begin
      @(negedge clk_sys_in);
      n++;
    end
    `CHK("early grants", 0, grants - g0)
  endtask : capture

  task automatic writes(input int n, input int gap, input int exp_g);
    int g0;
    g0 = grants;
    for (int k = 0; k < n; k++) begin
      @(negedge clk_sys_in) cfg_write_req_in = 1'b1;
      if (gap != 0) @(negedge clk_sys_in) cfg_write_req_in = 1'b0;
    end
    @(negedge clk_sys_in) cfg_write_req_in = 1'b0;
    repeat (3) @(negedge clk_sys_in);
    `CHK("grants", exp_g, grants - g0)
  endtask : writes

  task automatic pulse_reset(input int n);
    srst_in = 1'b1;
    repeat (n) @(negedge clk_sys_in);
    srst_in = 1'b0;
    @(negedge clk_sys_in);
    `CHK("reset straps", 7'h70, straps)
    `CHK("reset valid", 1'b0, valid)
  endtask : pulse_reset

  task automatic close_out();
    if (mismatches == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : close_out

  // ==========================================================================
  // Clock, watchdog and main sequence.
  initial begin
    clk_sys_in = 1'b0;
    forever #5 clk_sys_in = ~clk_sys_in;
  end

  initial begin
    #100000;
    mismatches++;
    close_out();
  end

  initial begin
    srst_in = 1'b1;
    rst_pin_n_in = 1'b0;
    proc_id_zero_in = 1'b1;
    cfg_write_req_in = 1'b0;
    ovr_en = 7'h00;
    ovr_val = 7'h00;
    last = 7'h00;
    fe_prev = 7'h00;
    mismatches = 0;
    total_checks = 0;
    grants = 0;
    void'($urandom(32'hDE9A));
    @(negedge clk_sys_in);
    pulse_reset(9);
    capture(4'h0, 4'h0);
    writes(3, 0, 1);
    capture(4'hF, 4'hF);
    writes(3, 0, 3);
    for (i = 0; i < 4; i++) begin
      capture(4'($urandom), 4'($urandom));
      writes(2, 1, last[3] ? 2 : 1);
    end
    // Off processor zero the pulls on the boot and write straps are absent, so the board drives them.
    proc_id_zero_in = 1'b0;
    capture(4'hF, 4'h5);
    proc_id_zero_in = 1'b1;
    capture(4'hF, 4'hA);
    @(negedge clk_sys_in) rst_pin_n_in = 1'b0;
    pulse_reset(3);
    capture(4'h0, 4'h0);
    writes(1, 1, 1);
    close_out();
  end
endmodule : tb_reset_strap_mode_capture

bind rsmc_capture rsmc_capture_sva u_sva (.clk_sys_in(clk_sys_in), .srst_in(srst_in),
  .rst_pin_n_in(rst_pin_n_in), .strap_pins_in(strap_pins_in), .proc_id_zero_in(proc_id_zero_in),
  .cfg_write_req_in(cfg_write_req_in), .pad_pull_up_en_out(pad_pull_up_en_out),
  .pad_pull_down_en_out(pad_pull_down_en_out), .pad_func_en_out(pad_func_en_out), .straps_out(straps_out),
  .straps_valid_out(straps_valid_out), .boot_from_memory_out(boot_from_memory_out),
  .boot_wait_external_out(boot_wait_external_out), .ext_irq_enable_out(ext_irq_enable_out),
  .ext_irq_level_sense_out(ext_irq_level_sense_out), .link_rx_width_4bit_out(link_rx_width_4bit_out),
  .cfg_write_grant_out(cfg_write_grant_out));

`default_nettype wire
